// ===== rsc_combiner.sv
// Reset source combiner with reset cause register behind an APB slave.
// Assumes every source input is an asynchronous level from outside pclk,
// and that presetn is the power-on reset of this block itself.
//
// The APB register port and the register addresses were decided locally.
`default_nettype none

// Summary of operation
// - Accept eight reset source kinds as inputs.
// - Any active source asserts system reset output.
// - Reset forces some registers; others keep contents.
// - Every reset kind sets its own flag.
// - Power-on clears set bits, keeps power-on flag.
// - Software sets/clears flags; no reset results.
// - Bit 15 flags trap conflict reset.
// - Bit 14 flags illegal opcode/address/uninit register.
// - Bits 13 to 10 read zero.
// - Bit 9 flags configuration mismatch reset.
// - Bit 8 keeps regulator active in sleep.
// - Bit 7 flags master clear pin reset.
// - Bit 6 flags reset instruction.
// - Bit 5 enables watchdog unless config forces.
// - Bit 4 flags watchdog time-out.
// - Bit 3 flags wake from sleep.
// - Bit 2 flags wake from idle.
// - Bit 1 flags brown-out reset.
// - Bit 0 flags power-on reset.
module rsc_combiner (
  input wire logic pclk,                          // System clock, 10 MHz.
  input wire logic presetn,                       // Asynchronous reset, active low.
  input wire logic ce,                            // Clock enable; all state holds while low.
  input wire logic psel,                          // APB select.
  input wire logic penable,                       // APB enable.
  input wire logic pwrite,                        // APB direction, high for write.
  input wire logic [rsc_pkg::ADDR_W-1:0] paddr,   // APB byte address.
  input wire logic [31:0] pwdata,                 // APB write data.
  output logic [31:0] prdata,                     // APB read data.
  output logic pready,                            // APB ready.
  output logic pslverr,                           // APB error for unmapped address.
  input wire logic power_on_det,                  // Power-on detector active, high.
  input wire logic brownout_det,                  // Brown-out detector active, high.
  input wire logic master_clear_pin_n,            // External master clear pin, active low.
  input wire logic reset_instr,                   // Reset instruction executed, high.
  input wire logic watchdog_timer_expired,        // Watchdog time-out, high.
  input wire logic config_mismatch_det,           // Configuration mismatch, high.
  input wire logic trap_conflict_det,             // Trap conflict, high.
  input wire logic illegal_opcode_det,            // Illegal opcode, high.
  input wire logic illegal_addr_mode_det,         // Illegal addressing mode, high.
  input wire logic uninit_wreg_det,               // Uninitialised working register used, high.
  input wire logic security_violation_det,        // Security violation, high.
  input wire logic woke_from_sleep,               // Device has been in sleep, high.
  input wire logic woke_from_idle,                // Device has been in idle, high.
  input wire logic watchdog_config_enable,        // Watchdog fuse, high when unprogrammed.
  output logic system_reset_out,                  // Combined system reset, high active.
  output logic regulator_sleep_active,            // Regulator stays on in sleep.
  output logic watchdog_run                       // Effective watchdog enable.
);

  // ----------------------------------------------------------------------
  // Source synchronisation
  // ----------------------------------------------------------------------
  // The wake and fuse levels share the synchroniser with the reset sources,
  // so every asynchronous input sees the same two-flop latency.
  rsc_src_if src_bus ();

  logic [rsc_pkg::SRC_W-1:0] raw_vec;

  always_comb
  begin
    // The pin is inverted here so that every bit of the vector is active high.
    raw_vec = '0;
    raw_vec[rsc_pkg::SRC_POR] = power_on_det;
    raw_vec[rsc_pkg::SRC_BOR] = brownout_det;
    raw_vec[rsc_pkg::SRC_MASTER_CLEAR_PIN] = ~master_clear_pin_n;
    raw_vec[rsc_pkg::SRC_INSTR] = reset_instr;
    raw_vec[rsc_pkg::SRC_WDT] = watchdog_timer_expired;
    raw_vec[rsc_pkg::SRC_CFG] = config_mismatch_det;
    raw_vec[rsc_pkg::SRC_TRAP] = trap_conflict_det;
    raw_vec[rsc_pkg::SRC_ILL_OPC] = illegal_opcode_det;
    raw_vec[rsc_pkg::SRC_ILL_ADDR] = illegal_addr_mode_det;
    raw_vec[rsc_pkg::SRC_ILL_UNINIT] = uninit_wreg_det;
    raw_vec[rsc_pkg::SRC_ILL_SEC] = security_violation_det;
    raw_vec[rsc_pkg::SRC_SLEEP] = woke_from_sleep;
    raw_vec[rsc_pkg::SRC_IDLE] = woke_from_idle;
    raw_vec[rsc_pkg::SRC_WDT_CFG] = watchdog_config_enable;
  end

  assign src_bus.raw = raw_vec;

  rsc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .src(src_bus.sync_mp)
  );

  logic [rsc_pkg::SRC_W-1:0] src_s;
  assign src_s = src_bus.synced;

  // Each illegal-condition variant folds into one cause.
  logic illegal_any;
  assign illegal_any = src_s[rsc_pkg::SRC_ILL_OPC] | src_s[rsc_pkg::SRC_ILL_ADDR] |
                       src_s[rsc_pkg::SRC_ILL_UNINIT] | src_s[rsc_pkg::SRC_ILL_SEC];

  // Wake flags sit above the reset sources in the vector and stay out of the
  // combined reset: waking from a power-saving mode is not a reset.
  logic any_reset_src;
  assign any_reset_src = |src_s[rsc_pkg::SRC_RESET_W-1:0];

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Ready is registered so every output comes from a flop; each access
  // phase therefore takes two cycles, the second being the completing edge.
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic access_first;
  logic access_done;
  logic hit_cause;
  logic hit_stat;
  logic hit_any;
  logic cause_wr;

  // Only the two register words decode; every other byte address is
  // refused with an error so that a stray pointer is caught by software.
  always_comb
  begin
    hit_cause = 1'b0;
    hit_stat = 1'b0;
    case (paddr)
      rsc_pkg::OFS_RESET_CAUSE:
      begin
        hit_cause = 1'b1;
      end
      rsc_pkg::OFS_SOURCE_STAT:
      begin
        hit_stat = 1'b1;
      end
      default:
      begin
        hit_cause = 1'b0;
        hit_stat = 1'b0;
      end
    endcase
  end

  assign hit_any = hit_cause | hit_stat;
  assign access_first = psel & penable & ~pready_r;
  assign access_done = psel & penable & pready_r;
  assign cause_wr = access_done & pwrite & hit_cause;

  logic [15:0] cause_r;
  logic [15:0] cause_nxt;
  logic sys_rst_r;
  logic [15:0] stat_word;
  logic [31:0] read_word;

  // The status word shows the live synchronised sources and the combined
  // reset, so software can poll for a source that is still held.
  always_comb
  begin
    stat_word = '0;
    stat_word[rsc_pkg::SRC_RESET_W-1:0] = src_s[rsc_pkg::SRC_RESET_W-1:0];
    stat_word[15] = sys_rst_r;
  end

  // The read word is captured in the first access cycle, so a flag set in
  // the completing cycle shows only on the next read; the register keeps it,
  // so it is never lost.
  always_comb
  begin
    read_word = 32'h00000000;
    if (!pwrite && hit_cause)
    begin
      read_word = {16'h0000, cause_r};
    end
    else if (!pwrite && hit_stat)
    begin
      read_word = {16'h0000, stat_word};
    end
  end

  // Ready rises for one cycle and then drops by itself, which gives the
  // one wait state that every access takes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
    end
    else if (ce)
    begin
      pready_r <= access_first;
    end
  end

  // The error stands with ready only; it is low in every other cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr_r <= 1'b0;
    end
    else if (ce)
    begin
      pslverr_r <= access_first & ~hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
    end
    else if (ce)
    begin
      if (access_first)
      begin
        prdata_r <= read_word;
      end
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // ----------------------------------------------------------------------
  // Reset cause register
  // ----------------------------------------------------------------------
  // Hardware causes are OR-ed in after the software write so that a cause
  // arriving in the same cycle as a clear is never lost.
  logic [15:0] hw_set;

  always_comb
  begin
    hw_set = '0;
    hw_set[rsc_pkg::BIT_POWER_ON] = src_s[rsc_pkg::SRC_POR];
    hw_set[rsc_pkg::BIT_BROWNOUT] = src_s[rsc_pkg::SRC_BOR];
    hw_set[rsc_pkg::BIT_WAKE_IDLE] = src_s[rsc_pkg::SRC_IDLE];
    hw_set[rsc_pkg::BIT_WAKE_SLEEP] = src_s[rsc_pkg::SRC_SLEEP];
    hw_set[rsc_pkg::BIT_WDT_TIMEOUT] = src_s[rsc_pkg::SRC_WDT];
    hw_set[rsc_pkg::BIT_INSTR_RESET] = src_s[rsc_pkg::SRC_INSTR];
    hw_set[rsc_pkg::BIT_PIN_RESET] = src_s[rsc_pkg::SRC_MASTER_CLEAR_PIN];
    hw_set[rsc_pkg::BIT_CFG_MISMATCH] = src_s[rsc_pkg::SRC_CFG];
    hw_set[rsc_pkg::BIT_ILLEGAL] = illegal_any;
    hw_set[rsc_pkg::BIT_TRAP] = src_s[rsc_pkg::SRC_TRAP];
  end

  always_comb
  begin
    cause_nxt = cause_r;
    if (src_s[rsc_pkg::SRC_POR])
    begin
      // Power-on wipes everything but its own flag and a live brown-out.
      cause_nxt = rsc_pkg::RESET_CAUSE_POR_VAL &
                  ((16'h0001 << rsc_pkg::BIT_POWER_ON) | hw_set);
    end
    else
    begin
      if (cause_wr)
      begin
        // A software write only stores; it never requests a reset.
        cause_nxt = pwdata[15:0] & rsc_pkg::RESET_CAUSE_WR_MASK;
      end
      // Warm resets only add flags; control bits keep their contents.
      cause_nxt = cause_nxt | hw_set;
    end
  end

  // A write that lands while power-on is still seen active is dropped: the
  // power-on value must win so that the cause reads without ambiguity.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause_r <= rsc_pkg::RESET_CAUSE_POR_VAL;
    end
    else if (ce)
    begin
      cause_r <= cause_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Combined reset and control outputs
  // ----------------------------------------------------------------------
  // Reset is set by presetn and then follows the synchronised sources,
  // which costs two cycles of extra latency on release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_rst_r <= 1'b1;
    end
    else if (ce)
    begin
      sys_rst_r <= any_reset_src;
    end
  end

  assign system_reset_out = sys_rst_r;

  logic reg_sleep_r;
  logic wdt_run_r;

  // Both controls follow the next register value so that they change on
  // the same edge as the register bit that software wrote.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reg_sleep_r <= 1'b0;
    end
    else if (ce)
    begin
      reg_sleep_r <= cause_nxt[rsc_pkg::BIT_REG_SLEEP];
    end
  end

  // The fuse level passes the same synchroniser as the sources, so a change
  // of the fuse reaches the watchdog enable three edges later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_run_r <= 1'b0;
    end
    else if (ce)
    begin
      wdt_run_r <= src_s[rsc_pkg::SRC_WDT_CFG] |
                   cause_nxt[rsc_pkg::BIT_WDT_SOFT_EN];
    end
  end

  assign regulator_sleep_active = reg_sleep_r;
  assign watchdog_run = wdt_run_r;

endmodule : rsc_combiner

`default_nettype wire

// ===== rsc_pkg.sv
// Constants shared by the reset source combiner and its input synchroniser.
// Assumes a 32-bit APB slave port and one 16-bit reset cause register.
`default_nettype none

package rsc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h00;
  localparam logic [7:0] OFS_SOURCE_STAT = 8'h04;
  localparam int ADDR_W = 8;
  localparam int REG_W = 16;

  // ----------------------------------------------------------------------
  // Bit positions in the reset cause register
  // ----------------------------------------------------------------------
  localparam int BIT_POWER_ON = 0;
  localparam int BIT_BROWNOUT = 1;
  localparam int BIT_WAKE_IDLE = 2;
  localparam int BIT_WAKE_SLEEP = 3;
  localparam int BIT_WDT_TIMEOUT = 4;
  localparam int BIT_WDT_SOFT_EN = 5;
  localparam int BIT_INSTR_RESET = 6;
  localparam int BIT_PIN_RESET = 7;
  localparam int BIT_REG_SLEEP = 8;
  localparam int BIT_CFG_MISMATCH = 9;
  localparam int BIT_ILLEGAL = 14;
  localparam int BIT_TRAP = 15;

  localparam logic [15:0] RESET_CAUSE_POR_VAL = 16'h0003;
  localparam logic [15:0] RESET_CAUSE_WR_MASK = 16'hC3FF;

  // ----------------------------------------------------------------------
  // Index of each raw input in the synchronised vector
  // ----------------------------------------------------------------------
  localparam int SRC_POR = 0;
  localparam int SRC_BOR = 1;
  localparam int SRC_MASTER_CLEAR_PIN = 2;
  localparam int SRC_INSTR = 3;
  localparam int SRC_WDT = 4;
  localparam int SRC_CFG = 5;
  localparam int SRC_TRAP = 6;
  localparam int SRC_ILL_OPC = 7;
  localparam int SRC_ILL_ADDR = 8;
  localparam int SRC_ILL_UNINIT = 9;
  localparam int SRC_ILL_SEC = 10;
  localparam int SRC_SLEEP = 11;
  localparam int SRC_IDLE = 12;
  localparam int SRC_WDT_CFG = 13;
  localparam int SRC_W = 14;
  localparam int SRC_RESET_W = 11;

  localparam logic [SRC_W-1:0] SYNC_RESET_VAL = 14'h0000;

endpackage : rsc_pkg

`default_nettype wire

// ===== rsc_src_if.sv
// Carries the raw reset source levels to the synchroniser and the
// synchronised copies back to the combiner. Assumes both ends share pclk.
`default_nettype none

interface rsc_src_if;
  logic [rsc_pkg::SRC_W-1:0] raw;
  logic [rsc_pkg::SRC_W-1:0] synced;

  modport sync_mp (input raw, output synced);
  modport comb_mp (output raw, input synced);
endinterface : rsc_src_if

`default_nettype wire

// ===== rsc_sync.sv
// Two-flop synchroniser for every asynchronous reset source level.
// Assumes raw inputs may change at any time relative to pclk.
`default_nettype none

module rsc_sync (
  input wire logic pclk,         // System clock.
  input wire logic presetn,      // Asynchronous reset, active low.
  input wire logic ce,           // Clock enable; state holds while low.
  rsc_src_if.sync_mp src         // Raw levels in, synchronised levels out.
);

  // ----------------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------------
  // The first stage feeds only the second; nothing else looks at it.
  logic [rsc_pkg::SRC_W-1:0] meta_r;
  logic [rsc_pkg::SRC_W-1:0] stable_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= rsc_pkg::SYNC_RESET_VAL;
      stable_r <= rsc_pkg::SYNC_RESET_VAL;
    end
    else if (ce)
    begin
      meta_r <= src.raw;
      stable_r <= meta_r;
    end
  end

  assign src.synced = stable_r;

endmodule : rsc_sync

`default_nettype wire

// ===== rsc_monitor.sv
// Checker for the port behaviour of the reset source combiner.
// Assumes it is bound to rsc_combiner; the fuse check counts only enabled cycles.
`default_nettype none

module rsc_monitor (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [rsc_pkg::ADDR_W-1:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic power_on_det, // Source.
  input wire logic brownout_det, // Source.
  input wire logic master_clear_pin_n, // Source, active low.
  input wire logic reset_instr, // Source.
  input wire logic watchdog_timer_expired, // Source.
  input wire logic config_mismatch_det, // Source.
  input wire logic trap_conflict_det, // Source.
  input wire logic illegal_opcode_det, // Source.
  input wire logic illegal_addr_mode_det, // Source.
  input wire logic uninit_wreg_det, // Source.
  input wire logic security_violation_det, // Source.
  input wire logic watchdog_config_enable, // Watchdog fuse.
  input wire logic system_reset_out, // Combined reset.
  input wire logic regulator_sleep_active, // Regulator control.
  input wire logic watchdog_run // Watchdog enable.
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  logic any_src;
  assign any_src = power_on_det | brownout_det | !master_clear_pin_n | reset_instr | watchdog_timer_expired
    | config_mismatch_det | trap_conflict_det | illegal_opcode_det | illegal_addr_mode_det | uninit_wreg_det
    | security_violation_det;

  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence apb_setup;
    psel && !penable && ce;
  endsequence
  sequence apb_wait;
    !pready ##1 pready;
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  rst_hold_a: assert property (disable iff (1'h0) !presetn |-> system_reset_out && !pready)
    else $error("reset state wrong");
  src_assert_a: assert property (any_src [*3] |=> system_reset_out)
    else $error("system reset not asserted");
  src_release_a: assert property (!any_src [*3] |=> !system_reset_out)
    else $error("system reset not released");
  ready_wait_a: assert property (apb_setup |=> apb_wait)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  unmapped_err_a: assert property (pready && paddr != 8'h00 && paddr != 8'h04 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  upper_zero_a: assert property (pready && !pwrite && paddr == 8'h00 |-> !pslverr && prdata[31:10] == 22'h0 ||
    !pslverr && prdata[31:16] == 16'h0 && prdata[13:10] == 4'h0)
    else $error("unimplemented bits not zero");
  reg_sleep_a: assert property (pready && pwrite && paddr == 8'h00 && !power_on_det |-> ##2
    regulator_sleep_active == $past(pwdata[8], 2))
    else $error("regulator control not following write");
  wdt_force_a: assert property ((watchdog_config_enable && ce) [*3] |=> watchdog_run)
    else $error("watchdog not forced on");
endmodule : rsc_monitor

bind rsc_combiner rsc_monitor rsc_monitor_inst (.*);

`default_nettype wire

// ===== rsc_src_model.sv
// Model of the reset detectors, wake flags and master clear pin.
// Assumes the bench raises one bit of fire for one clock per event.
`default_nettype none

module rsc_src_model #(
  parameter int HOLD = 4 // Cycles a source stays active.
) (
  input wire logic pclk, // Clock.
  input wire logic [12:0] fire, // One-hot event start.
  output logic power_on_det, // Power-on.
  output logic brownout_det, // Brown-out.
  output logic master_clear_pin_n, // Pin, pulled up when idle.
  output logic reset_instr, // Reset instruction.
  output logic watchdog_timer_expired, // Watchdog time-out.
  output logic config_mismatch_det, // Configuration mismatch.
  output logic trap_conflict_det, // Trap conflict.
  output logic illegal_opcode_det, // Illegal opcode.
  output logic illegal_addr_mode_det, // Illegal addressing.
  output logic uninit_wreg_det, // Uninitialised register.
  output logic security_violation_det, // Security violation.
  output logic woke_from_sleep, // Sleep wake.
  output logic woke_from_idle // Idle wake.
);
  int cnt [13] = '{default: 0};
  logic [12:0] lvl;
  logic pin_act;

  always @(posedge pclk)
  begin
    for (int i = 0; i < 13; i++)
    begin
      if (fire[i])
        cnt[i] <= HOLD;
      else if (cnt[i] != 0)
        cnt[i] <= cnt[i] - 1;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 13; i++)
      lvl[i] = cnt[i] != 0;
  end

  assign {woke_from_idle, woke_from_sleep, security_violation_det, uninit_wreg_det, illegal_addr_mode_det,
    illegal_opcode_det, trap_conflict_det, config_mismatch_det, watchdog_timer_expired, reset_instr, pin_act,
    brownout_det, power_on_det} = lvl;
  assign master_clear_pin_n = !pin_act;
endmodule : rsc_src_model

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the reset source combiner over APB.
// Assumes the detector model and the bound checker are compiled with it.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'h0;
  logic presetn = 1'h1;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [rsc_pkg::ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, system_reset_out, regulator_sleep_active, watchdog_run;
  logic power_on_det, brownout_det, master_clear_pin_n, reset_instr, watchdog_timer_expired;
  logic config_mismatch_det, trap_conflict_det, illegal_opcode_det, illegal_addr_mode_det;
  logic uninit_wreg_det, security_violation_det, woke_from_sleep, woke_from_idle;
  logic watchdog_config_enable = 1'h0;
  logic [12:0] fire = 13'h0000;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int total_checks = 0;

  rsc_combiner rsc_combiner_inst (.*);
  rsc_src_model #(.HOLD(4)) rsc_src_model_inst (.*);

  initial
  begin
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'h1)
      failures++;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_power_up;
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0003);
    apb(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h0);
  endtask : t_power_up

  task automatic t_software;
    apb(1'h1, 8'h00, 32'hFFFF_FFFF);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0000_C3FF);
    chk({31'h0, system_reset_out}, 32'h0);
    chk({31'h0, regulator_sleep_active}, 32'h1);
    chk({31'h0, watchdog_run}, 32'h1);
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, regulator_sleep_active, watchdog_run}, 32'h0);
    watchdog_config_enable <= 1'h1;
    repeat (5) @(posedge pclk);
    watchdog_config_enable <= 1'h0;
    @(negedge pclk);
    chk({31'h0, watchdog_run}, 32'h1);
    repeat (4) @(posedge pclk);
    chk({31'h0, watchdog_run}, 32'h0);
    // With the clock enable low the fuse level must not reach the output.
    ce <= 1'h0;
    watchdog_config_enable <= 1'h1;
    repeat (5) @(posedge pclk);
    watchdog_config_enable <= 1'h0;
    repeat (3) @(posedge pclk);
    ce <= 1'h1;
    chk({31'h0, watchdog_run}, 32'h0);
  endtask : t_software

  task automatic t_unmapped;
    apb(1'h0, 8'h08, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'h1, 8'h04, 32'h0000_FFFF);
    chk({31'h0, er}, 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0);
  endtask : t_unmapped

  // Each source in turn; power-on is preset with stale bits that it must clear.
  task automatic t_sources;
    int bitpos [13] = '{0, 1, 7, 6, 4, 9, 15, 14, 14, 14, 14, 3, 2};
    for (int i = 0; i < 13; i++)
    begin
      apb(1'h1, 8'h00, (i == 0) ? 32'h0000_01F6 : 32'h0);
      fire <= 13'h0001 << i;
      @(posedge pclk);
      fire <= 13'h0000;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, system_reset_out}, (i < 11) ? 32'h1 : 32'h0);
      repeat (6) @(posedge pclk);
      chk({31'h0, system_reset_out}, 32'h0);
      apb(1'h0, 8'h00, 32'h0);
      chk(rd, 32'h1 << bitpos[i]);
    end
  endtask : t_sources

  task automatic t_midreset;
    apb(1'h1, 8'h00, 32'h0000_0180);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0003);
  endtask : t_midreset

  initial
  begin
    presetn <= 1'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    t_power_up();
    t_software();
    t_unmapped();
    t_sources();
    t_midreset();
    final_report();
  end

  initial
  begin
    #400000;
    failures++;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
